// file: logic/cfs_pkg.sv
// Constants, register map and types for the cooling fan supervisor
package cfs_pkg;
   localparam logic [11:0] CFS_OFF_CTRL = 12'h000;
   localparam logic [11:0] CFS_OFF_FSEL = 12'h004;
   localparam logic [11:0] CFS_OFF_STAT = 12'h008;
   localparam logic [11:0] CFS_OFF_IRQ_STAT = 12'h00C;
   localparam logic [11:0] CFS_OFF_IRQ_EN = 12'h010;
   localparam logic [11:0] CFS_OFF_IRQ_CLR = 12'h014;
   // Control register bits
   localparam int CFS_CTRL_POLICY = 0;
   localparam int CFS_CTRL_ACTION = 1;
   localparam int CFS_CTRL_TRIP_RST = 2;
   // Status register fields
   localparam int CFS_STAT_IN_LSB = 0;
   localparam int CFS_STAT_FAN = 5;
   localparam int CFS_STAT_TRIP = 6;
   localparam int CFS_STAT_STATE_LSB = 7;
   // Function select fields
   localparam int CFS_FSEL_DO_LSB = 0;
   localparam int CFS_FSEL_RLY_LSB = 8;
   localparam int CFS_FSEL_W = 5;
   localparam logic [4:0] CFS_FUNC_FAULT = 5'h11;
   localparam logic [4:0] CFS_FUNC_FAN_ALARM = 5'h12;
   localparam logic [4:0] CFS_DO_RESET = 5'h0C;
   localparam logic [4:0] CFS_RLY_RESET = 5'h11;
   localparam logic CFS_POLICY_RESET = 1'b0;
   localparam logic CFS_ACTION_RESET = 1'b0;
   // Interrupt status bits
   localparam int CFS_IRQ_W = 4;
   localparam int CFS_IRQ_FAN_FAULT = 0;
   localparam int CFS_IRQ_TRIP = 1;
   localparam int CFS_IRQ_OVERTEMP = 2;
   localparam int CFS_IRQ_FAN_CHG = 3;
   localparam int CFS_SYNC_STAGES = 2;
   localparam logic [31:0] CFS_ZERO = 32'h0000_0000;
   typedef enum logic [1:0] {CFS_OFF, CFS_ON_POWER, CFS_ON_RUN, CFS_ON_HOT}
      cfs_fan_state_t;
endpackage

// file: logic/cfs_supervisor.sv
// Cooling fan supervisor: fan switching, fan fault handling, APB registers
//
// Summary of operation
// - Policy 0: fan on as soon as power is good, regardless of run.
// - Policy 0: fan off only when main circuit falls to low voltage.
// - Policy 1: fan runs once power is good and run command is on.
// - Policy 1: fan stops when run is off and output is shut off.
// - Policy 1: heatsink overtemperature keeps fan running regardless of run.
// - Action 0: drive keeps operating after a fan fault.
// - Output select 18 drives fan fault alarm while a fan fault exists.
// - Action 1: fan fault stops the drive and raises a fault indication.
// - With action 1, output select 17 shows the general fault on trip.
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
module cfs_supervisor
   import cfs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic power_good,
   input wire logic run_cmd,
   input wire logic output_active,
   input wire logic heatsink_hot,
   input wire logic fan_fault,
   output logic fan_on,
   output logic drive_stop,
   output logic fault_display,
   output logic digital_output,
   output logic relay_output,
   output logic irq
);
   logic [4:0] raw_in;
   logic [4:0] sync_in;
   logic pg_s;
   logic run_s;
   logic act_s;
   logic hot_s;
   logic ff_s;
   logic policy_q;
   logic action_q;
   logic [CFS_FSEL_W-1:0] do_sel_q;
   logic [CFS_FSEL_W-1:0] rly_sel_q;
   logic trip_q;
   logic [CFS_IRQ_W-1:0] irq_stat_q;
   logic [CFS_IRQ_W-1:0] irq_en_q;
   logic [CFS_IRQ_W-1:0] irq_set;
   logic [CFS_IRQ_W-1:0] irq_clr;
   logic [CFS_IRQ_W-1:0] irq_stat_d;
   logic [CFS_IRQ_W-1:0] irq_en_d;
   logic ff_prev_q;
   logic hot_prev_q;
   logic fan_prev_q;
   cfs_fan_state_t state_q;
   cfs_fan_state_t state_d;
   logic fan_d;
   logic want_power;
   logic want_run;
   logic run_idle;
   logic hot_hold;
   logic do_d;
   logic rly_d;
   logic [31:0] ctrl_word;
   logic [31:0] fsel_word;
   logic [31:0] stat_word;
   logic [31:0] istat_word;
   logic [31:0] ien_word;
   logic [31:0] rdata_d;

   assign raw_in = {fan_fault, heatsink_hot, output_active, run_cmd,
                    power_good};

   // Every drive indication is asynchronous to pclk
   cfs_sync #(.W(5)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(raw_in),
      .sync_out(sync_in)
   );
   assign pg_s = sync_in[0];
   assign run_s = sync_in[1];
   assign act_s = sync_in[2];
   assign hot_s = sync_in[3];
   assign ff_s = sync_in[4];

   // APB decode; zero wait states, no error answers
   wire apb_setup = psel && !penable;
   wire apb_acc = psel && penable;
   wire apb_wr = apb_acc && pwrite;
   wire apb_rd_setup = apb_setup && !pwrite;
   wire hit_ctrl = paddr == CFS_OFF_CTRL;
   wire hit_fsel = paddr == CFS_OFF_FSEL;
   wire hit_stat = paddr == CFS_OFF_STAT;
   wire hit_istat = paddr == CFS_OFF_IRQ_STAT;
   wire hit_ien = paddr == CFS_OFF_IRQ_EN;
   wire hit_iclr = paddr == CFS_OFF_IRQ_CLR;
   wire wr_ctrl = apb_wr && hit_ctrl;
   wire wr_fsel = apb_wr && hit_fsel;
   wire wr_ien = apb_wr && hit_ien;
   wire wr_iclr = apb_wr && hit_iclr;

   // Switching conditions named once, shared by the states below
   assign want_power = pg_s && !policy_q;
   assign want_run = pg_s && run_s;
   assign run_idle = !run_s && !act_s;
   assign hot_hold = policy_q && hot_s;

   // Fan switching decision
   always_comb begin
      state_d = state_q;
      case (state_q)
         CFS_OFF: begin
            if (want_power) begin
               state_d = CFS_ON_POWER;
            end else if (want_run) begin
               state_d = CFS_ON_RUN;
            end else if (hot_hold) begin
               state_d = CFS_ON_HOT;
            end
         end
         CFS_ON_POWER: begin
            // Policy change hands a running fan over to the run rules
            if (!pg_s) begin
               state_d = CFS_OFF;
            end else if (policy_q) begin
               state_d = CFS_ON_RUN;
            end
         end
         CFS_ON_RUN: begin
            // Power loss alone does not stop a fan started by run
            if (!policy_q) begin
               state_d = pg_s ? CFS_ON_POWER : CFS_OFF;
            end else if (run_idle) begin
               state_d = hot_s ? CFS_ON_HOT : CFS_OFF;
            end
         end
         CFS_ON_HOT: begin
            if (!policy_q) begin
               state_d = pg_s ? CFS_ON_POWER : CFS_OFF;
            end else if (want_run) begin
               state_d = CFS_ON_RUN;
            end else if (!hot_s) begin
               state_d = CFS_OFF;
            end
         end
         default: state_d = CFS_OFF;
      endcase
   end
   assign fan_d = state_d != CFS_OFF;

   // Trip latches until software resets it or action returns to continue
   wire trip_set = action_q && ff_s;
   wire trip_rst = wr_ctrl && pwdata[CFS_CTRL_TRIP_RST];
   wire trip_d = trip_set || (trip_q && !trip_rst && action_q);

   // Shared by both output pins so that they decode codes alike
   function automatic logic out_func(input logic [CFS_FSEL_W-1:0] sel,
                                     input logic alarm,
                                     input logic fault);
      if (sel == CFS_FUNC_FAN_ALARM) begin
         out_func = alarm;
      end else if (sel == CFS_FUNC_FAULT) begin
         out_func = fault;
      end else begin
         out_func = 1'b0;
      end
   endfunction
   assign do_d = out_func(do_sel_q, ff_s, trip_d);
   assign rly_d = out_func(rly_sel_q, ff_s, trip_d);

   // Edge events for the sticky status bits
   assign irq_set[CFS_IRQ_FAN_FAULT] = ff_s && !ff_prev_q;
   assign irq_set[CFS_IRQ_TRIP] = trip_d && !trip_q;
   assign irq_set[CFS_IRQ_OVERTEMP] = hot_s && !hot_prev_q;
   assign irq_set[CFS_IRQ_FAN_CHG] = fan_d != fan_prev_q;
   // A clear only drops bits that no event sets in the same cycle
   assign irq_clr = wr_iclr ? pwdata[CFS_IRQ_W-1:0] : '0;
   assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;
   assign irq_en_d = wr_ien ? pwdata[CFS_IRQ_W-1:0] : irq_en_q;

   // Read words; unused bits and the trip reset bit read as zero
   always_comb begin
      ctrl_word = CFS_ZERO;
      ctrl_word[CFS_CTRL_POLICY] = policy_q;
      ctrl_word[CFS_CTRL_ACTION] = action_q;
      fsel_word = CFS_ZERO;
      fsel_word[CFS_FSEL_DO_LSB +: CFS_FSEL_W] = do_sel_q;
      fsel_word[CFS_FSEL_RLY_LSB +: CFS_FSEL_W] = rly_sel_q;
      stat_word = CFS_ZERO;
      stat_word[CFS_STAT_IN_LSB +: $bits(sync_in)] = sync_in;
      stat_word[CFS_STAT_FAN] = fan_on;
      stat_word[CFS_STAT_TRIP] = trip_q;
      stat_word[CFS_STAT_STATE_LSB +: $bits(state_q)] = state_q;
      istat_word = CFS_ZERO;
      istat_word[CFS_IRQ_W-1:0] = irq_stat_q;
      ien_word = CFS_ZERO;
      ien_word[CFS_IRQ_W-1:0] = irq_en_q;
   end

   always_comb begin
      rdata_d = CFS_ZERO;
      if (hit_ctrl) begin
         rdata_d = ctrl_word;
      end else if (hit_fsel) begin
         rdata_d = fsel_word;
      end else if (hit_stat) begin
         rdata_d = stat_word;
      end else if (hit_istat) begin
         rdata_d = istat_word;
      end else if (hit_ien) begin
         rdata_d = ien_word;
      end
   end

   // Software settings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         policy_q <= CFS_POLICY_RESET;
         action_q <= CFS_ACTION_RESET;
         do_sel_q <= CFS_DO_RESET;
         rly_sel_q <= CFS_RLY_RESET;
         irq_en_q <= '0;
      end else begin
         if (wr_ctrl) begin
            policy_q <= pwdata[CFS_CTRL_POLICY];
            action_q <= pwdata[CFS_CTRL_ACTION];
         end
         if (wr_fsel) begin
            do_sel_q <= pwdata[CFS_FSEL_DO_LSB +: CFS_FSEL_W];
            rly_sel_q <= pwdata[CFS_FSEL_RLY_LSB +: CFS_FSEL_W];
         end
         if (wr_ien) begin
            irq_en_q <= pwdata[CFS_IRQ_W-1:0];
         end
      end
   end

   // Fan state, registered fan output and edge history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= CFS_OFF;
         fan_on <= 1'b0;
         fan_prev_q <= 1'b0;
         trip_q <= 1'b0;
         ff_prev_q <= 1'b0;
         hot_prev_q <= 1'b0;
      end else begin
         state_q <= state_d;
         fan_on <= fan_d;
         fan_prev_q <= fan_d;
         trip_q <= trip_d;
         ff_prev_q <= ff_s;
         hot_prev_q <= hot_s;
      end
   end

   // Fault outputs track the registered trip and fault levels
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_stop <= 1'b0;
         fault_display <= 1'b0;
         digital_output <= 1'b0;
         relay_output <= 1'b0;
      end else begin
         drive_stop <= trip_d;
         fault_display <= trip_d;
         digital_output <= do_d;
         relay_output <= rly_d;
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_q <= '0;
         irq <= 1'b0;
      end else begin
         irq_stat_q <= irq_stat_d;
         irq <= |(irq_stat_d & irq_en_d);
      end
   end

   // Read data captured in setup so it stands through the access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= CFS_ZERO;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         if (apb_rd_setup) begin
            prdata <= rdata_d;
         end
         pready <= apb_setup;
         pslverr <= 1'b0;
      end
   end
endmodule // cfs_supervisor

// file: logic/cfs_sync.sv
// Two-flop synchroniser bank for asynchronous drive indications
`timescale 1ns/1ps
module cfs_sync #(
   parameter int W = 5
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // cfs_sync

// file: tb/cfs_fan_model.sv
// Behavioural cooling fan that reports a fault while told to stall
`timescale 1ns/1ps
module cfs_fan_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic stall,
   output logic fan_fault
);
   // Sensor lags the stall by one edge, like a slow tacho check
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) fan_fault <= 1'b0;
      else fan_fault <= stall;
   end
endmodule // cfs_fan_model

// file: tb/cfs_supervisor_props.sv
// Concurrent checks on the cooling fan supervisor ports
`timescale 1ns/1ps
module cfs_supervisor_props
   import cfs_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic power_good,
   input wire logic run_cmd,
   input wire logic output_active,
   input wire logic heatsink_hot,
   input wire logic fan_fault,
   input wire logic fan_on,
   input wire logic drive_stop,
   input wire logic fault_display,
   input wire logic digital_output,
   input wire logic relay_output
);
   logic [1:0] ctl_q;
   logic [4:0] do_q;
   logic [4:0] rl_q;
   // Shadow of the settings, since they are not visible at the pins
   wire wr_en = psel && penable && pwrite && pready;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_q <= 2'h0;
         do_q <= CFS_DO_RESET;
         rl_q <= CFS_RLY_RESET;
      end else if (wr_en && paddr == CFS_OFF_CTRL) begin
         ctl_q <= pwdata[1:0];
      end else if (wr_en && paddr == CFS_OFF_FSEL) begin
         do_q <= pwdata[4:0];
         rl_q <= pwdata[12:8];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup; psel && !penable; endsequence
   sequence s_access; psel && penable; endsequence
   property p_ready; s_setup ##1 s_access |-> pready && !pslverr; endproperty
   property p_pol0_on; (!ctl_q[0] && power_good)[*4] |-> fan_on; endproperty
   property p_pol0_off; (!ctl_q[0] && !power_good)[*4] |-> !fan_on;
   endproperty
   property p_pol1_run; (ctl_q[0] && power_good && run_cmd)[*4] |-> fan_on;
   endproperty
   property p_pol1_stop;
      (ctl_q[0] && !run_cmd && !output_active && !heatsink_hot)[*4]
         |-> !fan_on;
   endproperty
   property p_hot; (ctl_q[0] && heatsink_hot)[*4] |-> fan_on; endproperty
   property p_cont; (!ctl_q[1])[*2] |-> !drive_stop; endproperty
   property p_trip; (ctl_q[1] && fan_fault)[*4] |-> drive_stop && fault_display;
   endproperty
   property p_alarm;
      (do_q == CFS_FUNC_FAN_ALARM && fan_fault)[*4] |-> digital_output;
   endproperty
   property p_fault_out;
      (rl_q == CFS_FUNC_FAULT && drive_stop)[*2] |-> relay_output;
   endproperty
   a_ready: assert property (p_ready) else $error("pready missing");
   a_pol0_on: assert property (p_pol0_on) else $error("fan off");
   a_pol0_off: assert property (p_pol0_off) else $error("fan on");
   a_pol1_run: assert property (p_pol1_run) else $error("fan off");
   a_pol1_stop: assert property (p_pol1_stop) else $error("fan on");
   a_hot: assert property (p_hot) else $error("fan off when hot");
   a_cont: assert property (p_cont) else $error("stop in action 0");
   a_trip: assert property (p_trip) else $error("no trip");
   a_alarm: assert property (p_alarm) else $error("no alarm");
   a_fault_out: assert property (p_fault_out) else $error("no fault");
endmodule // cfs_supervisor_props
bind cfs_supervisor cfs_supervisor_props cfs_supervisor_props_inst (.pclk,
   .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
   .power_good, .run_cmd, .output_active, .heatsink_hot, .fan_fault,
   .fan_on, .drive_stop, .fault_display, .digital_output, .relay_output);

// file: tb/tb.sv
// Self-checking bench for the cooling fan supervisor
`timescale 1ns/1ps
module tb;
   import cfs_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stall = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd, lf = 32'hd489_23ea;
   logic pready, pslverr, fan_fault, fan_on, drive_stop, fault_display;
   logic digital_output, relay_output, irq;
   logic power_good = 0, run_cmd = 0, output_active = 0, heatsink_hot = 0;
   int fails = 0, compares = 0, m_fan = 0, m_run = 0, pol = 0, i;
   always #10 pclk = ~pclk;
   cfs_supervisor cfs_supervisor_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .power_good(power_good), .run_cmd(run_cmd), .fan_on(fan_on),
      .output_active(output_active), .heatsink_hot(heatsink_hot),
      .fan_fault(fan_fault), .drive_stop(drive_stop), .irq(irq),
      .fault_display(fault_display), .digital_output(digital_output),
      .relay_output(relay_output));
   cfs_fan_model cfs_fan_model_inst (.pclk(pclk), .presetn(presetn),
      .stall(stall), .fan_fault(fan_fault));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task end_sim;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // Values read at the edge are those the design samples there
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fails++;
         end_sim();
      end
      rd = prdata;
      {psel, penable} <= 2'b00;
   endtask
   task setin(input logic [3:0] v);
      @(posedge pclk);
      {power_good, run_cmd, output_active, heatsink_hot} <= v;
      repeat (4) @(posedge pclk);
      #1;
      // Policy 1 keeps a run-started fan until run and output are off
      if (v[3] && v[2]) begin
         m_run = 1;
      end else if (!v[2] && !v[1]) begin
         m_run = 0;
      end
      m_fan = pol ? (m_run | v[0]) : v[3];
      chk("fan_on", m_fan, fan_on);
   endtask
   task settle(input int c);
      repeat (c) @(posedge pclk);
      #1;
   endtask
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, CFS_OFF_CTRL, 0);
      chk("ctrl", 32'h0000_0000, rd);
      apb(0, CFS_OFF_FSEL, 0);
      chk("fsel", 32'h0000_110C, rd);
      apb(1, 12'h020, 32'hFFFF_FFFF);
      apb(0, 12'h020, 0);
      chk("unmapped", 32'h0000_0000, rd);
      $display("registers done");
      for (i = 0; i < 8; i++) begin
         lf = lfsr(lf);
         setin(lf[3:0]);
      end
      $display("policy 0 done");
      pol = 1;
      apb(1, CFS_OFF_CTRL, 32'h0000_0001);
      setin(4'h0);
      setin(4'h1);
      for (i = 0; i < 16; i++) begin
         lf = lfsr(lf);
         setin({1'b1, lf[2:0]});
      end
      $display("policy 1 done");
      apb(1, CFS_OFF_FSEL, 32'h0000_1212);
      apb(1, CFS_OFF_IRQ_EN, 32'h0000_0001);
      stall <= 1'b1;
      settle(6);
      chk("digital_output", 1, digital_output);
      chk("relay_output", 1, relay_output);
      chk("drive_stop", 0, drive_stop);
      chk("irq", 1, irq);
      apb(1, CFS_OFF_IRQ_EN, 0);
      settle(2);
      chk("irq masked", 0, irq);
      apb(1, CFS_OFF_IRQ_EN, 32'h0000_0001);
      apb(1, CFS_OFF_IRQ_CLR, 32'h0000_0001);
      settle(2);
      chk("irq cleared", 0, irq);
      stall <= 1'b0;
      $display("continue on fault done");
      apb(1, CFS_OFF_FSEL, 32'h0000_1111);
      apb(1, CFS_OFF_CTRL, 32'h0000_0003);
      stall <= 1'b1;
      settle(6);
      chk("drive_stop", 1, drive_stop);
      chk("fault_display", 1, fault_display);
      chk("fault out", 2'h3, {digital_output, relay_output});
      stall <= 1'b0;
      settle(6);
      chk("trip held", 1, drive_stop);
      apb(0, CFS_OFF_STAT, 0);
      chk("stat trip", 1, rd[CFS_STAT_TRIP]);
      apb(1, CFS_OFF_CTRL, 32'h0000_0007);
      settle(3);
      chk("trip reset", 0, drive_stop);
      apb(0, CFS_OFF_IRQ_STAT, 0);
      chk("irq_stat", 32'h0000_000F, rd);
      $display("stop on fault done");
      end_sim();
   end
endmodule // tb
